// ---- pkg/drfc_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the refresh controller.
// Assumes inclusion by bare name from the package and the testbench.
// Overview of operation
// [RULE_01] Bit 7 enables refresh; reset sets it.
// [RULE_02] Bit 6 stretches refresh to three clocks.
// [RULE_03] Interval field selects 10/20/40/80 states.
// [RULE_04] Reset clears interval field to shortest.
// [RULE_05] After reset: every 10 clocks, 3 long.
// [RULE_06] No refresh in reset, hold, sleep, wait.
// [RULE_07] Timer keeps counting while bus released.
// [RULE_08] Refresh request latched, later ones overwrite.
// [RULE_09] Latched refresh runs after first machine cycle.
// [RULE_10] Address advances once per performed refresh.
// [RULE_11] Timer restarts at reset release and request.
// [RULE_12] Writes apply next interval (here a new interval limit applies to the current count at once); reads return settings.
`ifndef DRFC_REGS_SVH
`define DRFC_REGS_SVH
`define DRFC_REFRESH_CONTROL_ADDR 8'h36
`define DRFC_ON_BIT               7
`define DRFC_STRETCH_BIT          6
`define DRFC_SEL_HI               1
`define DRFC_SEL_LO               0
`define DRFC_REFRESH_CONTROL_RST  8'hC0
`define DRFC_READ_MASK            8'hC3
`define DRFC_STATES_SEL0          7'h0A
`define DRFC_STATES_SEL1          7'h14
`define DRFC_STATES_SEL2          7'h28
`define DRFC_STATES_SEL3          7'h50
`endif

// ---- pkg/drfc_pkg.sv ----
// Types shared by the refresh controller modules.
// Assumes the register header sits beside it.
`default_nettype none
package drfc_pkg;
    `include "drfc_regs.svh"
    typedef enum logic [1:0] {DRFC_IDLE, DRFC_T1, DRFC_T2, DRFC_TW} drfc_state_t;
    typedef logic [6:0] drfc_count_t;
endpackage : drfc_pkg
`default_nettype wire

// ---- hw/drfc_interval_timer.sv ----
// Free-running refresh interval timer giving a one-cycle request pulse.
// Assumes the interval selection comes straight from the control register.
`timescale 1ns/1ps
`default_nettype none
module drfc_interval_timer
    import drfc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [1:0] interval_sel,
    output var  logic       tick
);
    drfc_count_t count_reg;
    drfc_count_t count_next;
    drfc_count_t limit;
    wire         at_end;

    // Interval length in clock states for each selection code.
    // [RULE_03] interval code decode
    function automatic drfc_count_t states_of(input logic [1:0] sel);
        case (sel)
            2'h0:    states_of = `DRFC_STATES_SEL0;
            2'h1:    states_of = `DRFC_STATES_SEL1;
            2'h2:    states_of = `DRFC_STATES_SEL2;
            default: states_of = `DRFC_STATES_SEL3;
        endcase
    endfunction : states_of

    // A shortened selection ends the current count at once rather than wrapping.
    assign limit      = states_of(interval_sel) - 7'h01;
    assign at_end     = (count_reg >= limit);
    assign count_next = at_end ? 7'h00 : count_reg + 7'h01;

    // Counts in every state, bus held or not; restarts at reset and each request.
    // [RULE_07] [RULE_11] [RULE_12] timer keeps running
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count_reg <= 7'h00;
            tick      <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick      <= at_end;
        end
    end
endmodule : drfc_interval_timer
`default_nettype wire

// ---- hw/drfc_refresh_ctrl.sv ----
// Refresh controller: control register, request latch, refresh cycle sequencer, address.
// Assumes CPU-side signals are synchronous to clk_sys; io_wr and io_rd are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module drfc_refresh_ctrl
    import drfc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output var  logic [7:0] io_rdata,
    input  wire logic       bus_hold_request,
    input  wire logic       sleep_mode,
    input  wire logic       wait_state,
    input  wire logic       mcycle_end,
    output var  logic       refresh_cycle,
    output var  logic       refresh_wait_state,
    output var  logic [7:0] refresh_addr
);
    // Stored control fields, request latch and sequencer state.
    logic [7:0]  refresh_control_reg;
    logic [7:0]  refresh_control_next;
    logic        pending_reg;
    logic        pending_next;
    logic        sleep_seen_reg;
    logic        sleep_seen_next;
    drfc_state_t state_reg;
    drfc_state_t state_next;
    logic        tick;
    // Decoded strobes, qualifiers and next values of the registered outputs.
    wire         sel_hit;
    wire         wr_hit;
    wire         rd_hit;
    wire         refresh_enabled;
    wire         stretch_on;
    wire         blocked;
    wire         sleep_exit_ok;
    wire         start;
    wire         cycle_next;
    wire         stretch_next;
    wire         addr_step;
    wire [7:0]   rdata_next;
    wire [7:0]   addr_next;

    // True in every clock of a refresh bus cycle.
    // Used both to gate new starts and to drive the cycle flag.
    function automatic logic is_busy(input drfc_state_t st);
        is_busy = (st != DRFC_IDLE);
    endfunction : is_busy

    // Interval timer; it runs in every state so bus handover never shifts it.
    drfc_interval_timer u_timer (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .interval_sel (refresh_control_reg[`DRFC_SEL_HI:`DRFC_SEL_LO]),
        .tick         (tick)
    );

    // Register decode: the control register answers at a single I/O address.
    assign sel_hit = (io_addr == `DRFC_REFRESH_CONTROL_ADDR);
    assign wr_hit  = io_wr & sel_hit;
    assign rd_hit  = io_rd & sel_hit;

    // Spare bits are never stored, so a read shows only the live settings.
    // [RULE_12] write and readback
    assign refresh_control_next = io_wdata & `DRFC_READ_MASK;
    assign rdata_next           = rd_hit ? refresh_control_reg : 8'h00;

    // Live control fields used by the sequencer.
    // [RULE_01] refresh enable bit
    assign refresh_enabled = refresh_control_reg[`DRFC_ON_BIT];
    // [RULE_02] refresh stretch bit
    assign stretch_on      = refresh_control_reg[`DRFC_STRETCH_BIT];

    // Conditions that forbid inserting a cycle; reset is covered by the sync reset.
    // [RULE_06] suppress insertion conditions
    assign blocked = bus_hold_request | sleep_mode | wait_state;

    // After sleep the held request waits for the first machine cycle end.
    // [RULE_09] run after first cycle
    assign sleep_exit_ok = ~sleep_seen_reg | mcycle_end;

    // A cycle starts from the latch, never straight from the timer tick.
    assign start = pending_reg & ~blocked & refresh_enabled
                 & sleep_exit_ok & ~is_busy(state_reg);

    // Request latch: a new tick overwrites, never queues, and wins over the clear.
    // [RULE_08] single overwriting latch
    assign pending_next = tick | (pending_reg & ~start);

    // Sleep is remembered until a machine cycle ends after it or the held refresh
    // runs, so a sleep with nothing latched holds back later timer refreshes only until that machine cycle ends.
    assign sleep_seen_next = sleep_mode | (sleep_seen_reg & ~(start | mcycle_end));

    // Cycle flags follow the next state so the outputs come from flip-flops.
    // [RULE_02] [RULE_05] registered cycle flags
    assign cycle_next   = is_busy(state_next);
    assign stretch_next = (state_next == DRFC_TW);

    // Address steps at the end of the first clock of each performed cycle, never per request.
    // [RULE_10] increment per cycle
    assign addr_step = (state_reg == DRFC_T1);
    assign addr_next = refresh_addr + 8'h01;

    // Control register: enable and stretch set, interval shortest after reset.
    // [RULE_01] [RULE_02] [RULE_04] reset values
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            refresh_control_reg <= `DRFC_REFRESH_CONTROL_RST;
        end
        else if (wr_hit)
        begin
            refresh_control_reg <= refresh_control_next;
        end
    end

    // Read data register; it holds until the next read strobe.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            io_rdata <= 8'h00;
        end
        else if (io_rd)
        begin
            io_rdata <= rdata_next;
        end
    end

    // Request latch register.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pending_reg <= 1'b0;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    // Sleep memory register.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sleep_seen_reg <= 1'b0;
        end
        else
        begin
            sleep_seen_reg <= sleep_seen_next;
        end
    end

    // Refresh cycle sequencer: two clocks, or three with the stretch bit.
    // [RULE_02] [RULE_05] cycle length select
    always_comb
    begin
        case (state_reg)
            DRFC_IDLE: state_next = start ? DRFC_T1 : DRFC_IDLE;
            DRFC_T1:   state_next = DRFC_T2;
            DRFC_T2:   state_next = stretch_on ? DRFC_TW : DRFC_IDLE;
            DRFC_TW:   state_next = DRFC_IDLE;
            default:   state_next = DRFC_IDLE;
        endcase
    end

    // State and bus-cycle outputs, all registered.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg          <= DRFC_IDLE;
            refresh_cycle      <= 1'b0;
            refresh_wait_state <= 1'b0;
        end
        else
        begin
            state_reg          <= state_next;
            refresh_cycle      <= cycle_next;
            refresh_wait_state <= stretch_next;
        end
    end

    // Refresh address register; missed requests leave it untouched.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            refresh_addr <= 8'h00;
        end
        else if (addr_step)
        begin
            refresh_addr <= addr_next;
        end
    end
endmodule : drfc_refresh_ctrl
`default_nettype wire

// ---- testbench/drfc_dram_model.sv ----
// DRAM side: counts the refresh cycles it receives.
// Assumes refresh_cycle is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module drfc_dram_model (
    input  wire logic clk_sys,
    input  wire logic refresh_cycle,
    output var  int   rows_done
);
    logic was_reg = 1'b0;
    // Each new refresh cycle restores one row.
    always @(posedge clk_sys)
    begin
        was_reg <= refresh_cycle;
        if (refresh_cycle && !was_reg) rows_done <= rows_done + 1;
    end
endmodule : drfc_dram_model
`default_nettype wire

// ---- testbench/drfc_refresh_chk.sv ----
// Checker of refresh start, length and address stepping.
// Assumes a bind onto drfc_refresh_ctrl.
`timescale 1ns/1ps
`default_nettype none
module drfc_chk (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       bus_hold_request,
    input wire logic       sleep_mode,
    input wire logic       wait_state,
    input wire logic       refresh_cycle,
    input wire logic       refresh_wait_state,
    input wire logic [7:0] refresh_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence st; $rose(refresh_cycle); endsequence
    // A refresh starts only when unblocked and lasts two or three clocks.
    no_hold_a: assert property (st |-> !$past(bus_hold_request)) else $error("hold");
    no_sleep_a: assert property (st |-> !$past(sleep_mode)) else $error("sleep");
    no_wait_a: assert property (st |-> !$past(wait_state)) else $error("wait");
    min_len_a: assert property (st |=> refresh_cycle) else $error("short");
    max_len_a: assert property (st |-> ##3 !refresh_cycle) else $error("long");
    stretch_a: assert property (refresh_wait_state |-> $past(refresh_cycle,2))
        else $error("stretch");
    wait_inside_a: assert property (refresh_wait_state |-> refresh_cycle)
        else $error("wait state outside cycle");
    addr_step_a: assert property (st |-> ##3 refresh_addr == $past(refresh_addr,3) + 8'h01)
        else $error("step");
    addr_hold_a: assert property ($changed(refresh_addr) |-> $past(refresh_cycle))
        else $error("skip");
    long_c: cover property (refresh_wait_state);
    short_c: cover property ($fell(refresh_cycle) && !$past(refresh_wait_state));
    hold_c: cover property ($fell(bus_hold_request));
endmodule : drfc_chk
bind drfc_refresh_ctrl drfc_chk u_chk (.*);
`default_nettype wire

// ---- testbench/drfc_refresh_ctrl_tb.sv ----
// Bench: reset value, intervals, blocking and address stepping.
// Assumes the bound checker and the DRAM counter model.
`timescale 1ns/1ps
`default_nettype none
`include "drfc_regs.svh"
module drfc_refresh_ctrl_tb;
    localparam logic [7:0] RC = `DRFC_REFRESH_CONTROL_ADDR;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, mce = 1'b0, cyc;
    logic [2:0]  blk = 3'h0;
    logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, rdata, addr;
    logic [31:0] sd = 32'h15B3;
    int          miscompares, tests_run, p, c0, cnt;
    drfc_refresh_ctrl u_dut (.clk_sys, .sys_rst, .io_addr, .io_wdata, .io_wr, .io_rd,
        .io_rdata(rdata), .bus_hold_request(blk[0]), .sleep_mode(blk[1]), .wait_state(blk[2]),
        .mcycle_end(mce), .refresh_cycle(cyc), .refresh_wait_state(), .refresh_addr(addr));
    drfc_dram_model u_ram (.clk_sys, .refresh_cycle(cyc), .rows_done(cnt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) miscompares++;
        if (g !== e) $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    endtask : chk
    // One-clock strobe; read data is settled a clock later.
    task automatic acc(input logic [7:0] d, input logic w);
        @(posedge clk_sys) {io_addr, io_wdata, io_wr, io_rd} <= {RC, d, w, !w};
        @(posedge clk_sys) {io_wr, io_rd} <= 2'b00;
        @(negedge clk_sys);
    endtask : acc
    // Clocks between two refreshes seen by the DRAM.
    task automatic meas();
        p = 0;
        c0 = cnt;
        while (cnt == c0) @(negedge clk_sys);
        c0 = cnt;
        while (cnt == c0 && p < 900) @(negedge clk_sys) p++;
    endtask : meas
    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    initial forever #50 clk_sys = ~clk_sys;
    initial
    begin
        #1000000 miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        acc(8'h00, 1'b0);
        chk(rdata, `DRFC_REFRESH_CONTROL_RST);
        meas();
        chk(p, 10);
        // Every interval code with random spare and stretch bits.
        for (int s = 0; s < 4; s++)
        begin
            sd = lfsr(sd);
            acc({1'b1, sd[6:2], 2'(s)}, 1'b1);
            acc(8'h00, 1'b0);
            chk(rdata, {1'b1, sd[6:2], 2'(s)} & `DRFC_READ_MASK);
            meas();
            meas();
            chk(p, 10 << s);
        end
        // Hold, sleep and wait block refresh; each exit runs the held one.
        for (int k = 0; k < 3; k++)
        begin
            meas();
            @(posedge clk_sys) blk <= 3'h1 << k;
            repeat (200) @(posedge clk_sys);
            chk(cnt - c0, 1);
            {blk, mce} <= {3'h0, k == 1};
            @(posedge clk_sys) mce <= 1'b0;
            repeat (6) @(posedge clk_sys);
            chk(cnt - c0, 2);
            chk(addr, 8'(cnt));
        end
        acc(8'h00, 1'b1);
        c0 = cnt;
        repeat (100) @(posedge clk_sys);
        chk(cnt, c0);
        complete_run();
    end
endmodule : drfc_refresh_ctrl_tb
`default_nettype wire
